// file: rtl/sram_access_decode.sv
`timescale 1ns/1ps
module sram_access_decode #(
	parameter int ADDR_BITS = sram_base_pkg::SRAM_ADDR_BITS
)(
	// Register contents
	input  wire logic [31:0]            base_reg,
	// Core request
	input  wire sram_base_pkg::core_req_s req,
	// Decision
	output      sram_base_pkg::decision_s dec
);
	logic       in_region;
	logic       masked;
	logic       enabled;
	logic [4:0] mask_bits;

	always_comb
	begin
		mask_bits = base_reg[sram_base_pkg::AS_MASK_MSB:sram_base_pkg::AS_MASK_LSB];
		in_region = (req.addr[31:ADDR_BITS] == base_reg[31:ADDR_BITS]);
		masked    = mask_bits[req.space];
		enabled   = base_reg[sram_base_pkg::VALID_BIT];
		dec       = '0;
		if (req.valid)
		begin
			if (enabled && in_region && !masked)
			begin
				if (req.write && base_reg[sram_base_pkg::WP_BIT])
					dec.access_error = 1'b1;
				else
					dec.sram_select = 1'b1;
			end
			else
				dec.pass_on = 1'b1;
		end
	end
endmodule

// file: rtl/sram_base_access_control.sv
`timescale 1ns/1ps
module sram_base_access_control #(
	parameter int ADDR_BITS = sram_base_pkg::SRAM_ADDR_BITS
)(
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst_n,
	// Core register write
	input  wire logic                     core_reg_wr,
	input  wire logic [31:0]              core_reg_wdata,
	// Debugger register write
	input  wire logic                     dbg_reg_wr,
	input  wire logic [31:0]              dbg_reg_wdata,
	// Register readback
	output      logic [31:0]              base_rdata,
	// Core access
	input  wire sram_base_pkg::core_req_s core_req,
	// Access decision
	output      logic                     sram_enable,
	output      logic                     access_error,
	output      logic                     non_sram_ref
);
	// Stored fields; bits 7:6 have no flip-flops and always read as zero.
	localparam int          VALID_POS  = sram_base_pkg::VALID_BIT;
	localparam int          AS_LSB     = sram_base_pkg::AS_MASK_LSB;
	localparam int          AS_MSB     = sram_base_pkg::AS_MASK_MSB;
	localparam int          AS_WIDTH   = sram_base_pkg::AS_MASK_WIDTH;
	localparam int          WP_POS     = sram_base_pkg::WP_BIT;
	localparam int          HI_LSB     = sram_base_pkg::WP_BIT + 1;
	localparam int          HI_WIDTH   = 32 - HI_LSB;
	localparam logic [31:0] RESET_WORD = sram_base_pkg::BASE_RESET;

	typedef struct packed {
		logic [HI_WIDTH-1:0] base_hi;
		logic                write_protect;
		logic [AS_WIDTH-1:0] space_mask;
		logic                valid;
	} state_s;

	// Which port, if any, loads the register in this cycle.
	typedef enum logic [2:0] {
		SRC_NONE  = 3'b001,
		SRC_CORE  = 3'b010,
		SRC_DEBUG = 3'b100
	} wr_src_e;

	state_s                   state_reg;
	state_s                   state_next;
	wr_src_e                  wr_src;
	logic                     wr_any;
	logic [31:0]              wr_source;
	logic [31:0]              reg_word;
	sram_base_pkg::decision_s dec;

	// Debugger write wins a same-cycle collision so a halted core cannot block it.
	always_comb
	begin
		wr_src = SRC_NONE;
		if (dbg_reg_wr)
		begin
			wr_src = SRC_DEBUG;
		end
		else if (core_reg_wr)
		begin
			wr_src = SRC_CORE;
		end
	end

	// A write replaces every stored field at once; reserved bits are dropped.
	always_comb
	begin
		state_next = state_reg;
		wr_source  = core_reg_wdata;
		wr_any     = 1'b0;
		case (wr_src)
			SRC_CORE:
			begin
				wr_source = core_reg_wdata;
				wr_any    = 1'b1;
			end
			SRC_DEBUG:
			begin
				wr_source = dbg_reg_wdata;
				wr_any    = 1'b1;
			end
			default:
			begin
				wr_source = core_reg_wdata;
				wr_any    = 1'b0;
			end
		endcase
		if (wr_any)
		begin
			state_next.base_hi       = wr_source[31:HI_LSB];
			state_next.write_protect = wr_source[WP_POS];
			state_next.space_mask    = wr_source[AS_MSB:AS_LSB];
			state_next.valid         = wr_source[VALID_POS];
		end
	end

	// Only the register is reset; the array contents are left alone.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_reg.base_hi       <= RESET_WORD[31:HI_LSB];
			state_reg.write_protect <= RESET_WORD[WP_POS];
			state_reg.space_mask    <= RESET_WORD[AS_MSB:AS_LSB];
			state_reg.valid         <= RESET_WORD[VALID_POS];
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Readback rebuilds the word with the reserved bits held at zero.
	always_comb
	begin
		reg_word                = '0;
		reg_word[31:HI_LSB]     = state_reg.base_hi;
		reg_word[WP_POS]        = state_reg.write_protect;
		reg_word[AS_MSB:AS_LSB] = state_reg.space_mask;
		reg_word[VALID_POS]     = state_reg.valid;
	end

	sram_access_decode #(
		.ADDR_BITS(ADDR_BITS)
	) u_decode (
		.base_reg(reg_word),
		.req     (core_req),
		.dec     (dec)
	);

	assign base_rdata   = reg_word;
	assign sram_enable  = dec.sram_select;
	assign access_error = dec.access_error;
	assign non_sram_ref = dec.pass_on;
endmodule

// file: rtl/sram_base_pkg.sv
package sram_base_pkg;

	// Base register field positions.
	localparam int VALID_BIT      = 0;
	localparam int AS_MASK_LSB    = 1;
	localparam int AS_MASK_MSB    = 5;
	localparam int WP_BIT         = 8;
	localparam int RSVD_LSB       = 6;
	localparam int RSVD_MSB       = 7;
	localparam int AS_MASK_WIDTH  = 5;

	// Address-space mask bit order, counted from bit 1.
	localparam int AS_UD = 0;
	localparam int AS_UC = 1;
	localparam int AS_SD = 2;
	localparam int AS_SC = 3;
	localparam int AS_CI = 4;

	localparam logic [31:0] BASE_RESET = 32'h0000_0000;

	// Default memory size as a power of two in bytes (32 KiB).
	localparam int SRAM_ADDR_BITS = 15;

	typedef enum logic [2:0] {
		AS_USER_DATA  = 3'h0,
		AS_USER_CODE  = 3'h1,
		AS_SUPER_DATA = 3'h2,
		AS_SUPER_CODE = 3'h3,
		AS_CPU_SPACE  = 3'h4
	} access_space_e;

	typedef struct packed {
		logic          valid;
		logic [31:0]   addr;
		logic          write;
		access_space_e space;
	} core_req_s;

	typedef struct packed {
		logic sram_select;
		logic access_error;
		logic pass_on;
	} decision_s;

endpackage

// file: tb/core_model.sv
`timescale 1ns/1ps
module core_model(
	input wire logic clk_sys,
	input wire logic [31:0] base,
	output sram_base_pkg::core_req_s req
);
	int seed = 32'h7518;
	// Half the addresses land in the programmed region, the rest just outside it.
	always @(negedge clk_sys)
	begin
		req.valid <= 1'($random(seed));
		req.write <= 1'($random(seed));
		req.addr <= {base[31:15] ^ 17'($random(seed) & 1), 15'($random(seed))};
		req.space <= sram_base_pkg::access_space_e'(3'((($random(seed) & 32'hFF) % 5)));
	end
endmodule

// file: tb/sram_base_access_control_test.sv
`timescale 1ns/1ps
module sram_base_access_control_test;
	logic clk_sys = 0, rst_n = 0, cw = 0, dw = 0;
	logic [31:0] cd = 32'h0, dd = 32'h0, b = 32'h0, v, base_rdata;
	logic [7:0] lo;
	logic sram_enable, access_error, non_sram_ref;
	sram_base_pkg::core_req_s req;
	int bad_count = 0, check_count = 0, cyc = 0, seed = 32'h7518;
	localparam int AB = sram_base_pkg::SRAM_ADDR_BITS;
	initial forever #10 clk_sys = ~clk_sys;
	core_model u_core(.clk_sys(clk_sys), .base(base_rdata), .req(req));
	sram_base_access_control u_dut(.clk_sys(clk_sys), .rst_n(rst_n), .core_reg_wr(cw),
		.core_reg_wdata(cd), .dbg_reg_wr(dw), .dbg_reg_wdata(dd), .base_rdata(base_rdata),
		.core_req(req), .sram_enable(sram_enable), .access_error(access_error),
		.non_sram_ref(non_sram_ref));
	function automatic logic [31:0] exp_f(logic [31:0] r, sram_base_pkg::core_req_s q);
		if (!q.valid) return 32'h0;
		if (!r[0] || r[1 + q.space] || q.addr[31:AB] != r[31:AB]) return 32'h1;
		return (q.write && r[8]) ? 32'h2 : 32'h4;
	endfunction
	task final_report;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want)
		begin
			bad_count++;
			$display("CHECK FAILED %0t %h %h", $time, seen, want);
		end
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000) begin bad_count++; final_report; end
	end
	initial
	begin
		repeat (20) @(negedge clk_sys);
		rst_n <= 1;
		for (int i = 0; i < 3000; i++)
		begin
			@(negedge clk_sys);
			if (!rst_n)
				b = 32'h0;
			else if (dw)
				b = dd & 32'hFFFFFF3F;
			else if (cw)
				b = cd & 32'hFFFFFF3F;
			check(base_rdata, b);
			check({sram_enable, access_error, non_sram_ref}, exp_f(b, req));
			v = $random(seed);
			// Low bytes favour the three recommended settings.
			lo = v[5:4] == 0 ? 8'h2B : v[5:4] == 1 ? 8'h35 : v[5:4] == 2 ? 8'h21 : v[15:8];
			cw <= v[3:1] == 3'h0;
			dw <= v[3:0] == 4'h1 || v[3:0] == 4'h2;
			cd <= {v[31:8], lo};
			dd <= {v[31:8], lo} ^ 32'h100;
			rst_n <= i % 700 != 699;
		end
		final_report;
	end
endmodule

// file: tb/sram_base_props.sv
`timescale 1ns/1ps
module sram_base_props #(parameter int ADDR_BITS = sram_base_pkg::SRAM_ADDR_BITS)(
	input wire logic clk_sys, rst_n, core_reg_wr, dbg_reg_wr,
	input wire logic [31:0] core_reg_wdata, dbg_reg_wdata, base_rdata,
	input wire sram_base_pkg::core_req_s core_req,
	input wire logic sram_enable, access_error, non_sram_ref
);
	wire logic on = core_req.valid && base_rdata[0];
	wire logic msk = base_rdata[1 + core_req.space];
	wire logic hit = on && !msk && core_req.addr[31:ADDR_BITS] == base_rdata[31:ADDR_BITS];
	wire logic [2:0] outs = {sram_enable, access_error, non_sram_ref};
	localparam logic [31:0] KEEP = 32'hFFFFFF3F;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_core_wr; core_reg_wr && !dbg_reg_wr; endsequence
	a_wp_err: assert property (hit && core_req.write && base_rdata[8] |-> access_error)
		else $error("protected write not refused");
	a_mask_off: assert property (on && msk |-> non_sram_ref && !sram_enable)
		else $error("masked space reached memory");
	a_invalid_off: assert property (core_req.valid && !base_rdata[0] |-> non_sram_ref)
		else $error("invalid register served access");
	a_reset_clear: assert property (!$past(rst_n) |-> base_rdata == 32'h0)
		else $error("reset left register set");
	a_hit_serve: assert property (hit && !(core_req.write && base_rdata[8]) |->
		sram_enable)
		else $error("permitted hit not served");
	a_core_load: assert property (s_core_wr |=>
		base_rdata == ($past(core_reg_wdata) & KEEP))
		else $error("core write not loaded");
	a_dbg_load: assert property (dbg_reg_wr |=>
		base_rdata == ($past(dbg_reg_wdata) & KEEP))
		else $error("debugger write not loaded");
	a_one_result: assert property ($onehot0(outs) && core_req.valid == (|outs))
		else $error("decision not single");
endmodule
bind sram_base_access_control sram_base_props #(
	.ADDR_BITS(ADDR_BITS)
) u_props (
	.clk_sys       (clk_sys),
	.rst_n         (rst_n),
	.core_reg_wr   (core_reg_wr),
	.dbg_reg_wr    (dbg_reg_wr),
	.core_reg_wdata(core_reg_wdata),
	.dbg_reg_wdata (dbg_reg_wdata),
	.base_rdata    (base_rdata),
	.core_req      (core_req),
	.sram_enable   (sram_enable),
	.access_error  (access_error),
	.non_sram_ref  (non_sram_ref)
);
